// file: src/lsr_readout.sv
// Readout sequencer of a linear image sensor with a built-in timing generator,
// plus the FIFO that buffers pixel words on their way out.
// Assumes the start pulse is synchronous to i_clk and pixel values arrive per clock.
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Pixel FIFO
// ---------------------------------------------------------------
module lsr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Write side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  // Read side
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [WIDTH-1:0] rd_data_q;
  logic             rd_valid_q;

  wire logic do_wr   = i_wr_valid && o_wr_ready;
  wire logic head_ok = count_q != '0;
  wire logic take    = head_ok && (!rd_valid_q || i_rd_ready);

  assign o_wr_ready = count_q != (AW+1)'(DEPTH);
  assign o_rd_valid = rd_valid_q;
  assign o_rd_data  = rd_data_q;

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      count_q    <= '0;
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= AW'((wr_ptr_q + 1'b1) % DEPTH);
      end
      if (take) begin
        rd_ptr_q  <= AW'((rd_ptr_q + 1'b1) % DEPTH);
        rd_data_q <= mem[rd_ptr_q];
      end
      if (take) begin
        rd_valid_q <= 1'b1;
      end else if (i_rd_ready) begin
        rd_valid_q <= 1'b0;
      end
      count_q <= (AW+1)'(count_q + (do_wr ? 1'b1 : 1'b0) - (take ? 1'b1 : 1'b0));
    end
  end
endmodule : lsr_fifo

// ---------------------------------------------------------------
// Readout sequencer top
// ---------------------------------------------------------------
module lsr_readout
  import lsr_pkg::*;
#(
  parameter int NPIX  = PIXELS,
  parameter int PIXW  = PIX_W,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  // Controller side
  input  wire logic            i_start_pulse,
  // Pixel charge source
  input  wire logic [PIXW-1:0] i_pixel_value,
  // Sensor-side strobes and status
  output logic                 o_trig,
  output logic                 o_integrating,
  output logic                 o_line_end,
  output logic [15:0]          o_integ_cycles,
  // Pixel stream
  output logic                 o_pix_valid,
  output logic [PIXW-1:0]      o_pix_data,
  input  wire logic            i_pix_ready
);
  lsr_state_e  state_q;
  lsr_state_e  state_d;
  logic        start_q;
  logic [15:0] strobe_q;
  logic [15:0] pix_idx_q;
  logic [15:0] integ_q;
  logic [15:0] integ_len_q;
  logic        trig_q;
  logic        line_end_q;
  logic        fifo_ready;

  wire logic start_fall = start_q && !i_start_pulse;
  wire logic start_rise = !start_q && i_start_pulse;
  wire logic in_pixels  = (state_q == LSR_SHIFT) &&
                          (strobe_q >= 16'(FIRST_PIXEL_STROBE - 1));
  // Words are pushed only while the FIFO has room; a stall holds the pixel index, not the pixel value
  wire logic push       = in_pixels && fifo_ready;
  wire logic last_pix   = push && (pix_idx_q == 16'(NPIX - 1));

  // ---------------------------------------------------------------
  // State selection
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      LSR_IDLE:  if (start_rise) state_d = LSR_INTEG;
      LSR_INTEG: if (start_fall) state_d = LSR_SHIFT;
      LSR_SHIFT: begin
        if (start_fall) begin
          state_d = LSR_SHIFT;
        end else if (last_pix) begin
          state_d = i_start_pulse ? LSR_INTEG : LSR_IDLE;
        end
      end
      default:   state_d = LSR_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer state and strobes
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q    <= LSR_IDLE;
      start_q    <= 1'b0;
      trig_q     <= 1'b0;
      line_end_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      start_q    <= i_start_pulse;
      trig_q     <= (state_d == LSR_SHIFT);
      line_end_q <= last_pix;
    end
  end

  // ---------------------------------------------------------------
  // Exposure length
  // ---------------------------------------------------------------
  // Exposure counts every high cycle of the start pulse; longer phases wrap
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      integ_q     <= CNT_RST;
      integ_len_q <= CNT_RST;
    end else begin
      if (start_rise) begin
        integ_q <= 16'h0001;
      end else if (i_start_pulse) begin
        integ_q <= 16'(integ_q + 1'b1);
      end
      if (start_fall) begin
        integ_len_q <= integ_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Strobe and pixel counters
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strobe_q  <= CNT_RST;
      pix_idx_q <= CNT_RST;
    end else if (start_fall) begin
      strobe_q  <= CNT_RST;
      pix_idx_q <= CNT_RST;
    end else if (state_q == LSR_SHIFT) begin
      if (!in_pixels) begin
        strobe_q <= 16'(strobe_q + 1'b1);
      end
      if (push) begin
        pix_idx_q <= 16'(pix_idx_q + 1'b1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs and pixel buffer
  // ---------------------------------------------------------------
  assign o_trig         = trig_q;
  assign o_integrating  = start_q;
  assign o_line_end     = line_end_q;
  assign o_integ_cycles = integ_len_q;

  lsr_fifo #(
    .WIDTH (PIXW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_wr_valid (push),
    .i_wr_data  (i_pixel_value),
    .o_wr_ready (fifo_ready),
    .o_rd_valid (o_pix_valid),
    .o_rd_data  (o_pix_data),
    .i_rd_ready (i_pix_ready)
  );
endmodule : lsr_readout

// file: src/lsr_pkg.sv
// Constants shared by the line sensor readout logic
// Assumes one system clock of at most 10 MHz that also serves as the sensor clock
package lsr_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ            = 10;
  localparam int START_HIGH_MIN_CYC = 8;
  localparam int START_LOW_MIN_CYC  = 29;
  localparam int START_CYCLE_MIN    = 37;
  localparam int READOUT_MAX_MHZ    = 10;
  localparam int FIRST_PIXEL_STROBE = 30;
  // ---------------------------------------------------------------
  // Geometry and reset values
  // ---------------------------------------------------------------
  localparam int PIXELS             = 512;
  localparam int PIX_W              = 10;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LSR_IDLE  = 3'b001,
    LSR_INTEG = 3'b010,
    LSR_SHIFT = 3'b100
  } lsr_state_e;
endpackage : lsr_pkg

// file: sim/lsr_readout_assertions.sv
// Checker on the readout top ports
// Bound to every lsr_readout instance
`timescale 1ns/10ps
module lsr_chk #(parameter int PIXW = 10) (
  input wire logic            i_clk,
  input wire logic            i_rst,
  input wire logic            i_start_pulse,
  input wire logic [PIXW-1:0] i_pixel_value,
  input wire logic            o_trig,
  input wire logic            o_integrating,
  input wire logic            o_line_end,
  input wire logic [15:0]     o_integ_cycles,
  input wire logic            o_pix_valid,
  input wire logic [PIXW-1:0] o_pix_data,
  input wire logic            i_pix_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence fall_s; $fell(o_integrating); endsequence
  sequence stall_s; o_pix_valid && !i_pix_ready; endsequence
  start_trig_a: assert property (fall_s |-> o_trig) else $error("no strobe");
  integ_follow_a: assert property (i_start_pulse |=> o_integrating) else $error("no integ");
  run_strobe_a: assert property (fall_s |-> (o_trig && !o_line_end)[*8])
    else $error("strobe gap");
  end_after_a: assert property (o_line_end |-> $past(o_trig)) else $error("stray end");
  hold_word_a: assert property (stall_s |=> o_pix_valid && $stable(o_pix_data))
    else $error("word dropped");
endmodule : lsr_chk
bind lsr_readout lsr_chk #(.PIXW(PIXW)) chk (
  .i_clk          (i_clk),
  .i_rst          (i_rst),
  .i_start_pulse  (i_start_pulse),
  .i_pixel_value  (i_pixel_value),
  .o_trig         (o_trig),
  .o_integrating  (o_integrating),
  .o_line_end     (o_line_end),
  .o_integ_cycles (o_integ_cycles),
  .o_pix_valid    (o_pix_valid),
  .o_pix_data     (o_pix_data),
  .i_pix_ready    (i_pix_ready)
);

// file: sim/lsr_ctrl_model.sv
// Timing controller model driving the start pulse
// Assumes the sensor clock is the bench clock
`timescale 1ns/10ps
module lsr_ctrl_model
  import lsr_pkg::*;
(
  input wire logic i_clk,
  output logic     o_start_pulse
);
  initial o_start_pulse = 1'b0;
  // High phase sets the exposure; both phases clamped to their minimum
  task automatic pulse(input int hi, input int lo);
    @(posedge i_clk);
    #1 o_start_pulse = 1'b1;
    repeat (hi < START_HIGH_MIN_CYC ? START_HIGH_MIN_CYC : hi) @(posedge i_clk);
    #1 o_start_pulse = 1'b0;
    repeat (lo < START_LOW_MIN_CYC ? START_LOW_MIN_CYC : lo) @(posedge i_clk);
  endtask : pulse
endmodule : lsr_ctrl_model

// file: sim/tb_lsr_readout.sv
// Bench for lsr_readout with a controller model
// Assumes a short line of NPIX pixels
`timescale 1ns/10ps
module tb_lsr_readout;
  localparam int NPIX = 64;
  logic       i_clk, i_rst, i_pix_ready, o_trig, o_integrating, o_line_end, o_pix_valid;
  logic       st, prev, vchk;
  logic [9:0] pix, last, first, o_pix_data;
  logic [15:0] o_integ_cycles;
  int         bad_count, cmp_count, nw, nl, ns, cyc;
  lsr_ctrl_model ctrl (.i_clk(i_clk), .o_start_pulse(st));
  lsr_readout #(.NPIX(NPIX)) uut (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_start_pulse  (st),
    .i_pixel_value  (pix),
    .o_trig         (o_trig),
    .o_integrating  (o_integrating),
    .o_line_end     (o_line_end),
    .o_integ_cycles (o_integ_cycles),
    .o_pix_valid    (o_pix_valid),
    .o_pix_data     (o_pix_data),
    .i_pix_ready    (i_pix_ready)
  );
  initial begin
    i_clk = 1'b0;
    // Sensor clock at the highest pixel rate the sensor accepts
    forever #(500 / lsr_pkg::READOUT_MAX_MHZ) i_clk = ~i_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // Pixel value counts clocks since the fall; monitor checks word order
  always @(posedge i_clk) begin
    if (o_pix_valid && i_pix_ready && !i_rst) begin
      if (nw == 0) first = o_pix_data;
      else if (vchk && o_pix_data !== 10'h01E) check(o_pix_data, last + 1'b1);
      last = o_pix_data;
      nw++;
    end
    if (o_line_end) nl++;
    if (o_trig && !i_rst) ns++;
    if (++cyc > 20000) begin
      bad_count++;
      wrap_up();
    end
    pix <= #1 (prev && !st) ? 10'h001 : pix + 1'b1;
    prev = st;
  end
  task automatic clear;
    nw = 0;
    nl = 0;
    ns = 0;
  endtask : clear
  task automatic wait_line;
    for (int i = 0; i < 400 && nl == 0; i++) @(posedge i_clk);
    // Room for a full FIFO to drain after the last push
    repeat (40) @(posedge i_clk);
    #1;
  endtask : wait_line
  task automatic s_expose(input int hi);
    clear();
    ctrl.pulse(hi, 29);
    wait_line();
    check(o_integ_cycles, hi);
    check(first, 10'h01E);
    check(nw, NPIX);
    check(nl, 1);
    check(ns, lsr_pkg::FIRST_PIXEL_STROBE - 1 + NPIX);
  endtask : s_expose
  task automatic s_abort;
    clear();
    ctrl.pulse(12, 29);
    ctrl.pulse(8, 29);
    wait_line();
    check(nl, 1);
    check(last, 10'h01E + NPIX - 1);
  endtask : s_abort
  task automatic s_stall;
    clear();
    vchk = 1'b0;
    i_pix_ready = 1'b0;
    ctrl.pulse(8, 29);
    repeat (80) @(posedge i_clk);
    #1 check(o_pix_valid, 1);
    check(nl, 0);
    i_pix_ready = 1'b1;
    wait_line();
    check(nw, NPIX);
    check(nl, 1);
    vchk = 1'b1;
  endtask : s_stall
  initial begin
    i_rst = 1'b1;
    i_pix_ready = 1'b1;
    vchk = 1'b1;
    prev = 1'b0;
    pix = 10'h000;
    repeat (16) @(posedge i_clk);
    #1 i_rst = 1'b0;
    s_expose(8);
    s_expose(21);
    s_abort();
    s_stall();
    wrap_up();
  end
endmodule : tb_lsr_readout
